/* verilog/pmaacr_pkg.sv */
package pmaacr_pkg;
  // Register offsets within the PMA managed device
  localparam logic [15:0] PMAACR_OFS_ABILITY = 16'h0012;
  localparam logic [15:0] PMAACR_OFS_ROLE = 16'h0834;
  localparam logic [15:0] PMAACR_OFS_TEST = 16'h0836;
  // Managed device number that selects this bank
  localparam logic [4:0] PMAACR_DEV_PMA = 5'h01;
  // Field positions
  localparam int PMAACR_ROLE_BIT = 14;
  localparam int PMAACR_TEST_HI = 15;
  localparam int PMAACR_TEST_LO = 12;
  // Fixed read values
  localparam logic [15:0] PMAACR_ABILITY_VAL = 16'h0001;
  localparam logic [15:0] PMAACR_ROLE_FIXED = 16'h8000;
  localparam logic [11:0] PMAACR_TEST_LOW_VAL = 12'h001;
  localparam logic [3:0] PMAACR_TEST_RST = 4'h0;
  // Test mode codes
  localparam logic [3:0] PMAACR_TM_NORMAL = 4'h0;
  localparam logic [3:0] PMAACR_TM_MODE1 = 4'h2;
  localparam logic [3:0] PMAACR_TM_MODE2 = 4'h4;
  localparam logic [3:0] PMAACR_TM_MODE4 = 4'h8;
  localparam logic [3:0] PMAACR_TM_MODE5 = 4'ha;
  // Strap capture sequence
  typedef enum logic [1:0] {
    PMAACR_ST_LATCH = 2'b00,
    PMAACR_ST_RUN = 2'b01
  } pmaacr_state_t;
endpackage

/* verilog/pmaacr_field.sv */
`timescale 1ns/10ps
// Writable field with strap-loaded value; load wins over a write
module pmaacr_field
  import pmaacr_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic wr,
  input wire logic [W-1:0] wr_val,
  output logic [W-1:0] val
);
  typedef struct packed {
    logic [W-1:0] val;
  } pmaacr_fld_t;
  pmaacr_fld_t st_r;
  pmaacr_fld_t st_nxt;

  // Next value: strap load at reset release, else management write
  always_comb
  begin
    st_nxt = st_r;
    if (load)
      st_nxt.val = load_val;
    else if (wr)
      st_nxt.val = wr_val;
  end

  // Storage
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign val = st_r.val;
endmodule

/* verilog/pma_ability_control_regs.sv */
`timescale 1ns/10ps
// Operation
// [R1] Ability register reads 0x0001; bit 0 means single-pair 100 Mb/s; writes ignored.
// [R2] Role bit 14 of control register: 1 master, 0 slave.
// [R3] Role bit writable, reset from strap; bit 15 reads 1, 13:0 read 0.
// [R4] Test register bits 15:12 select transmitter test mode by fixed codes.
// [R5] Test field writable, strap reset defaulting normal; bits 11:0 read one.
// [R6] Master must select managed device one before accessing these registers.
// [R7] Role and test mode changes reach the line side without reset.
module pma_ability_control_regs
  import pmaacr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic strap_role_master,
  input wire logic [3:0] strap_test_mode,
  input wire logic [4:0] managed_device_select,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  output logic role_master,
  output logic [3:0] test_mode,
  output logic test_mode_valid
);
  typedef struct packed {
    pmaacr_state_t state;
    logic [15:0] rdata;
  } pmaacr_top_t;
  pmaacr_top_t st_r;
  pmaacr_top_t st_nxt;

  // Device select and per-register address matches
  logic dev_sel;
  logic addr_abil;
  logic addr_role;
  logic addr_test;
  logic addr_mapped;
  // Accesses the bank sees this cycle
  logic rd_take;
  logic wr_take;
  // Strap capture window and field write enables
  logic load;
  logic wr_role;
  logic wr_test;
  // Stored field values and the read words built from them
  logic role_val;
  logic [3:0] test_val;
  logic [15:0] role_word;
  logic [15:0] test_word;
  logic [15:0] rd_word;
  logic code_known;

  // Only accesses addressed to the PMA device are decoded
  // Everything else passes by untouched, so other banks may share the strobes
  assign dev_sel = (managed_device_select == PMAACR_DEV_PMA); // [R6]

  // Full 16-bit compare: partial decode would let a stray address alias a field
  assign addr_abil = (reg_addr == PMAACR_OFS_ABILITY); // [R1]
  assign addr_role = (reg_addr == PMAACR_OFS_ROLE); // [R3]
  assign addr_test = (reg_addr == PMAACR_OFS_TEST); // [R5]
  assign addr_mapped = addr_abil || addr_role || addr_test;

  // Strobes qualified by the device select
  assign rd_take = dev_sel && reg_rd;
  assign wr_take = dev_sel && reg_wr;

  // Straps are sampled on the first enabled edge after release, never under reset,
  // so a slow strap pin has the whole reset time to settle
  assign load = (st_r.state == PMAACR_ST_LATCH);

  // A write on the strap edge is dropped rather than raced against the strap value
  assign wr_role = wr_take && addr_role && !load; // [R3]
  assign wr_test = wr_take && addr_test && !load; // [R5]

  // Role bit storage
  // Ability register has no storage at all, so writes to it cannot land
  pmaacr_field #(.W(1)) u_role (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(load),
    .load_val(strap_role_master), // [R3]
    .wr(wr_role),
    .wr_val(reg_wdata[PMAACR_ROLE_BIT]),
    .val(role_val)
  );

  // Test mode field storage; a strap of zero gives normal operation
  pmaacr_field #(.W(4)) u_test (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(load),
    .load_val(strap_test_mode | PMAACR_TEST_RST), // [R5]
    .wr(wr_test),
    .wr_val(reg_wdata[PMAACR_TEST_HI:PMAACR_TEST_LO]),
    .val(test_val)
  );

  // Line side sees stored values directly, so writes act at once
  assign role_master = role_val; // [R2] [R7]
  assign test_mode = test_val; // [R4] [R7]

  // Known test codes; anything else is stored as written but flagged,
  // so the transmitter can fall back to normal operation on its own
  always_comb
  begin
    code_known = 1'b0;
    unique case (test_val)
      PMAACR_TM_NORMAL:
      begin
        code_known = 1'b1; // [R4]
      end
      PMAACR_TM_MODE1:
      begin
        code_known = 1'b1; // [R4]
      end
      PMAACR_TM_MODE2:
      begin
        code_known = 1'b1; // [R4]
      end
      PMAACR_TM_MODE4:
      begin
        code_known = 1'b1; // [R4]
      end
      PMAACR_TM_MODE5:
      begin
        code_known = 1'b1; // [R4]
      end
      default:
      begin
        code_known = 1'b0;
      end
    endcase
  end

  assign test_mode_valid = code_known; // [R4]

  // Hit decode: ability register ignores writes but still answers
  always_comb
  begin
    reg_hit = 1'b0;
    if (rd_take || wr_take)
    begin
      reg_hit = addr_mapped; // [R1]
    end
  end

  // Read words; reserved bits are constants so no write can disturb them
  assign role_word = PMAACR_ROLE_FIXED | {1'b0, role_val, 14'h0000}; // [R2] [R3]
  assign test_word = {test_val, PMAACR_TEST_LOW_VAL}; // [R5]

  // Read multiplexer; an unmapped address reads as zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (addr_abil)
    begin
      rd_word = PMAACR_ABILITY_VAL; // [R1]
    end
    else if (addr_role)
    begin
      rd_word = role_word; // [R2] [R3]
    end
    else if (addr_test)
    begin
      rd_word = test_word; // [R5]
    end
  end

  // Sequencer: one latch edge, then run until the next reset
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.state)
      PMAACR_ST_LATCH:
      begin
        st_nxt.state = PMAACR_ST_RUN;
      end
      PMAACR_ST_RUN:
      begin
        st_nxt.state = PMAACR_ST_RUN;
      end
      default:
      begin
        // Illegal code goes to run, not latch: a stray reload would undo writes
        st_nxt.state = PMAACR_ST_RUN;
      end
    endcase
    // Read data holds between reads so a slow master can take it late
    if (rd_take)
    begin
      st_nxt.rdata = rd_word;
    end
  end

  // State registers; clock enable low freezes strap capture and read data alike

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.state <= PMAACR_ST_LATCH;
      st_r.rdata <= 16'h0000;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
endmodule

/* verif/pmaacr_checker.sv */
`timescale 1ns/10ps
module pmaacr_checker
  import pmaacr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic role_master,
  input wire logic [3:0] test_mode,
  input wire logic test_mode_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Accesses the bank takes at this edge
  wire rd_ok = clk_en && reg_rd && reg_hit;
  wire wr_ok = clk_en && reg_wr && reg_hit;
  property p_abil; rd_ok && reg_addr == PMAACR_OFS_ABILITY |=> reg_rdata == 16'h0001; endproperty
  a_abil: assert property (p_abil) else $error("ability read wrong");
  property p_role; rd_ok && reg_addr == PMAACR_OFS_ROLE |=> reg_rdata == {1'b1, $past(role_master), 14'h0}; endproperty
  a_role: assert property (p_role) else $error("role read wrong");
  property p_wrole; wr_ok && reg_addr == PMAACR_OFS_ROLE |=> role_master == $past(reg_wdata[14]); endproperty
  a_wrole: assert property (p_wrole) else $error("role write lost");
  property p_tval; test_mode_valid == (test_mode inside {4'h0, 4'h2, 4'h4, 4'h8, 4'ha}); endproperty
  a_tval: assert property (p_tval) else $error("test code flag wrong");
  property p_test; rd_ok && reg_addr == PMAACR_OFS_TEST |=> reg_rdata == {$past(test_mode), 12'h001}; endproperty
  a_test: assert property (p_test) else $error("test read wrong");
  property p_wtest; wr_ok && reg_addr == PMAACR_OFS_TEST |=> test_mode == $past(reg_wdata[15:12]); endproperty
  a_wtest: assert property (p_wtest) else $error("test write lost");
  c_wrole: cover property (wr_ok && reg_addr == PMAACR_OFS_ROLE);
  c_wtest: cover property (wr_ok && reg_addr == PMAACR_OFS_TEST);
  c_rd: cover property (rd_ok);
endmodule

/* verif/pmaacr_mgmt_model.sv */
`timescale 1ns/10ps
module pmaacr_mgmt_model
  import pmaacr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic hit,
  output logic [4:0] dev,
  output logic [15:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  output logic hit_seen
);
  initial
  begin
    {dev, addr, wr, rd, wdata} = '0;
    hit_seen = 1'b0;
  end
  // One-cycle strobe; hit taken at the taking edge; released address and data invert, strobes clear
  task automatic acc_dev(input logic [4:0] dv, input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    dev = dv;
    {addr, wr, rd, wdata} = {a, w, !w, d};
    @(posedge ref_clk);
    hit_seen = hit;
    @(negedge ref_clk);
    {addr, wr, rd, wdata} = {~a, 2'b00, ~d};
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    acc_dev(PMAACR_DEV_PMA, w, a, d);
  endtask
endmodule

/* verif/pma_ability_control_regs_bench.sv */
`timescale 1ns/10ps
module pma_ability_control_regs_bench
  import pmaacr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] dev;
  logic [15:0] addr, wdata, rdata;
  logic wr, rd, hit, role, tval, hs;
  logic en = 1'b1;
  logic srole = 1'b1;
  logic [3:0] tm;
  logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'ha, 4'h3};
  int err_total = 0, checked = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  pmaacr_mgmt_model pmaacr_mgmt_model_inst (.ref_clk(ref_clk), .hit(hit), .dev(dev), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .hit_seen(hs));
  // Role strap starts high so its load shows against the zero reset, then low for the second reset
  pma_ability_control_regs pma_ability_control_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(en),
    .strap_role_master(srole), .strap_test_mode(4'h0), .managed_device_select(dev), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .role_master(role), .test_mode(tm),
    .test_mode_valid(tval));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    pmaacr_mgmt_model_inst.acc(1'b0, a, 16'h0000);
    chk(rdata, exp);
  endtask
  task automatic test_done;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, test needs well under 100 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    rdchk(PMAACR_OFS_ROLE, 16'hc000);
    rdchk(PMAACR_OFS_TEST, 16'h0001);
    pmaacr_mgmt_model_inst.acc(1'b1, PMAACR_OFS_ABILITY, 16'hffff);
    rdchk(PMAACR_OFS_ABILITY, 16'h0001);
    pmaacr_mgmt_model_inst.acc(1'b1, PMAACR_OFS_ROLE, 16'hbfff);
    chk({15'h0, role}, 16'h0000);
    rdchk(PMAACR_OFS_ROLE, 16'h8000);
    chk({15'h0, hs}, 16'h0001);
    pmaacr_mgmt_model_inst.acc_dev(5'h02, 1'b1, PMAACR_OFS_ROLE, 16'h4000);
    chk({15'h0, hs}, 16'h0000);
    chk({15'h0, role}, 16'h0000);
    en = 1'b0;
    pmaacr_mgmt_model_inst.acc(1'b1, PMAACR_OFS_ROLE, 16'h4000);
    chk({15'h0, role}, 16'h0000);
    en = 1'b1;
    foreach (codes[i])
    begin
      pmaacr_mgmt_model_inst.acc(1'b1, PMAACR_OFS_TEST, {codes[i], 12'hfff});
      chk({15'h0, tval}, 16'(i < 5));
      rdchk(PMAACR_OFS_TEST, {codes[i], 12'h001});
    end
    rst_b = 1'b0;
    srole = 1'b0;
    @(negedge ref_clk);
    rst_b = 1'b1;
    rdchk(PMAACR_OFS_ROLE, 16'h8000);
    rdchk(PMAACR_OFS_TEST, 16'h0001);
    test_done();
  end
endmodule
bind pma_ability_control_regs pmaacr_checker pmaacr_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .role_master(role_master), .test_mode(test_mode), .test_mode_valid(test_mode_valid));
